// >>> logic/cmts_defines.svh
// Purpose: constants of the control-mode and terminal-role switch
// Assumes: parameter values are held as 16-bit integers
// Notes: every offset is a byte address on the AXI4-Lite register port
// Function
// - methods 12 and 2: mode select off gives speed, on gives torque.
// - speed/torque switching is allowed at any time, stopped or running.
// - encoder vector method 4 toggles speed/position, method 5 torque/position.
// - while running, defer switches involving position until frequency reaches threshold.
// - analog terminal roles follow the active control mode.
// - methods 12/2, aux 0: speed auxiliary in speed, speed-limit auxiliary in torque.
// - setting 1 gives flux command in both modes, only under encoder vector.
// - aux 3: torque command in torque mode when torque-command source is 0.
// - aux 4: torque limit outside torque (source 1), torque command in torque (source 0).
// - aux 5: forward/reverse speed limit in torque when limit select is 2.
// - aux 2: regenerative torque limit outside torque mode when limit source 1.
// - method 4: aux 0 speed auxiliary, aux 6 torque bias, both speed only.
// - method 5: off is position, on is torque; aux 0 auxiliary in torque.
// - terminal 4 at 0: speed command or limit, only while its enable is on.
// - terminal 4 at 4, limit source 1: torque limit outside torque mode.
// - 9999, and aux 6 outside method 4, give no function.
// - second-function select swaps in the second motor control method.
`ifndef CMTS_DEFINES_SVH
`define CMTS_DEFINES_SVH

`define CMTS_OFF_METHOD1 8'h00
`define CMTS_OFF_METHOD2 8'h04
`define CMTS_OFF_AUXFUNC 8'h08
`define CMTS_OFF_T4FUNC 8'h0C
`define CMTS_OFF_SRCSEL 8'h10
`define CMTS_OFF_LOWSPD 8'h14
`define CMTS_OFF_STATUS 8'h18

`define CMTS_RST_METHOD1 16'h0014
`define CMTS_RST_METHOD2 16'h270F
`define CMTS_RST_AUXFUNC 16'h0000
`define CMTS_RST_T4FUNC 16'h0000
`define CMTS_RST_SRCSEL 16'h0000
`define CMTS_RST_LOWSPD 16'h0096

`define CMTS_SRC_TL_LSB 0
`define CMTS_SRC_TC_LSB 4
`define CMTS_SRC_SL_LSB 8

`define CMTS_ST_MODE_LSB 0
`define CMTS_ST_AUX_LSB 4
`define CMTS_ST_T4_LSB 8
`define CMTS_ST_PEND_BIT 12
`define CMTS_ST_SECOND_BIT 13

`define CMTS_M_SPEED 16'h0000
`define CMTS_M_TORQUE 16'h0001
`define CMTS_M_SPDTRQ 16'h0002
`define CMTS_M_POS 16'h0003
`define CMTS_M_SPDPOS 16'h0004
`define CMTS_M_POSTRQ 16'h0005
`define CMTS_M_SL_SPEED 16'h000A
`define CMTS_M_SL_TORQUE 16'h000B
`define CMTS_M_SL_SPDTRQ 16'h000C

`define CMTS_F_0 16'h0000
`define CMTS_F_1 16'h0001
`define CMTS_F_2 16'h0002
`define CMTS_F_3 16'h0003
`define CMTS_F_4 16'h0004
`define CMTS_F_5 16'h0005
`define CMTS_F_6 16'h0006
`define CMTS_SRC_PARAM1 4'h1
`define CMTS_SRC_ZERO 4'h0
`define CMTS_SL_FWDREV 4'h2

`endif

// >>> logic/cmts_pkg.sv
// Purpose: types of the control-mode and terminal-role switch
// Assumes: nothing beyond the defines header
// Notes: binary codes are visible in the status register
package cmts_pkg;

  typedef enum logic [1:0] {
    CMTS_SPEED = 2'h0,
    CMTS_TORQUE = 2'h1,
    CMTS_POSITION = 2'h2
  } cmts_mode_type;

  typedef enum logic [3:0] {
    CMTS_R_NONE = 4'h0,
    CMTS_R_SPD_AUX = 4'h1,
    CMTS_R_SPDLIM_AUX = 4'h2,
    CMTS_R_FLUX = 4'h3,
    CMTS_R_REGEN_TL = 4'h4,
    CMTS_R_TRQ_CMD = 4'h5,
    CMTS_R_TRQ_LIM = 4'h6,
    CMTS_R_FWDREV_LIM = 4'h7,
    CMTS_R_TRQ_BIAS = 4'h8,
    CMTS_R_SPD_CMD = 4'h9,
    CMTS_R_SPD_LIM = 4'hA
  } cmts_role_type;

endpackage

// >>> logic/cmts_dec_if.sv
// Purpose: carries decode inputs and the resulting role of one terminal
// Assumes: one instance per analog terminal
// Notes: plain wires, no clocking
`timescale 1ns/1ps
`default_nettype none
interface cmts_dec_if;
  import cmts_pkg::*;
  logic [15:0] func;
  logic [15:0] method;
  cmts_mode_type mode;
  logic [3:0] tlSrc;
  logic [3:0] tcSrc;
  logic [3:0] slSel;
  logic t4En;
  cmts_role_type role;
  modport ctl (output func, method, mode, tlSrc, tcSrc, slSel, t4En, input role);
  modport dec (input func, method, mode, tlSrc, tcSrc, slSel, t4En, output role);
endinterface
`default_nettype wire

// >>> logic/cmts_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module cmts_sync #(parameter int WIDTH = 1) (
  input wire logic mclk, // clock
  input wire logic nrst, // async reset, low
  input wire logic [WIDTH-1:0] din, // pin levels
  output logic [WIDTH-1:0] dout // synchronised levels
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end
  assign dout = stage2_ff;
endmodule
`default_nettype wire

// >>> logic/cmts_term_decode.sv
// Purpose: role of one analog terminal for a function setting and mode
// Assumes: mode is the mode about to become active
// Notes: IS_AUX selects the auxiliary-terminal table, else terminal 4
`timescale 1ns/1ps
`default_nettype none
`include "cmts_defines.svh"
module cmts_term_decode import cmts_pkg::*; #(parameter bit IS_AUX = 1'b1) (
  cmts_dec_if.dec io // decode inputs and role
);
  wire encVector = (io.method <= `CMTS_M_POSTRQ);
  wire isSpeed = (io.mode == CMTS_SPEED);
  wire isTorque = (io.mode == CMTS_TORQUE);
  wire tlParam = (io.tlSrc == `CMTS_SRC_PARAM1);
  wire tcZero = (io.tcSrc == `CMTS_SRC_ZERO);
  wire m4 = (io.method == `CMTS_M_SPDPOS);
  wire m5 = (io.method == `CMTS_M_POSTRQ);
  always_comb begin
    io.role = CMTS_R_NONE;
    if (IS_AUX) begin
      case (io.func)
        `CMTS_F_0: begin
          if (m4) io.role = isSpeed ? CMTS_R_SPD_AUX : CMTS_R_NONE;
          else if (m5) io.role = isTorque ? CMTS_R_SPD_AUX : CMTS_R_NONE;
          else if (isSpeed) io.role = CMTS_R_SPD_AUX;
          else if (isTorque) io.role = CMTS_R_SPDLIM_AUX;
        end
        `CMTS_F_1: io.role = encVector ? CMTS_R_FLUX : CMTS_R_NONE;
        `CMTS_F_2: if (!isTorque && tlParam) io.role = CMTS_R_REGEN_TL;
        `CMTS_F_3: if (isTorque && tcZero) io.role = CMTS_R_TRQ_CMD;
        `CMTS_F_4: begin
          if (!isTorque && tlParam) io.role = CMTS_R_TRQ_LIM;
          else if (isTorque && tcZero) io.role = CMTS_R_TRQ_CMD;
        end
        `CMTS_F_5: if (isTorque && io.slSel == `CMTS_SL_FWDREV) io.role = CMTS_R_FWDREV_LIM;
        `CMTS_F_6: if (m4 && isSpeed) io.role = CMTS_R_TRQ_BIAS;
        default: io.role = CMTS_R_NONE;
      endcase
    end else begin
      case (io.func)
        `CMTS_F_0: begin
          if (io.t4En && isSpeed) io.role = CMTS_R_SPD_CMD;
          else if (io.t4En && isTorque) io.role = CMTS_R_SPD_LIM;
        end
        `CMTS_F_1: io.role = encVector ? CMTS_R_FLUX : CMTS_R_NONE;
        `CMTS_F_4: if (!isTorque && tlParam) io.role = CMTS_R_TRQ_LIM;
        default: io.role = CMTS_R_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> logic/cmts_switch.sv
// Purpose: selects speed, torque or position control and terminal roles
// Assumes: outFreq and motorRunning come from drive logic on mclk
// Notes: parameters are written over AXI4-Lite; status is read-only
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cmts_defines.svh"
module cmts_switch import cmts_pkg::*; (
  input wire logic mclk, // 100 MHz clock
  input wire logic nrst, // async reset, low
  input wire logic modeSelIn, // mode select pin
  input wire logic term4EnIn, // terminal 4 enable pin
  input wire logic secondFuncIn, // second function select pin
  input wire logic motorRunning, // drive is running
  input wire logic [15:0] outFreq, // output frequency
  output logic [1:0] activeMode, // active control mode
  output logic [3:0] auxRole, // aux terminal role
  output logic [3:0] term4Role, // terminal 4 role
  output logic switchPending, // position switch deferred
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready // read response ready
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // parameter registers
  logic [15:0] method1_ff;
  logic [15:0] method2_ff;
  logic [15:0] auxFunc_ff;
  logic [15:0] t4Func_ff;
  logic [15:0] srcSel_ff;
  logic [15:0] lowSpd_ff;

  // write channel state
  logic awHeld_ff;
  logic wHeld_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  // read channel state
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // control state
  cmts_mode_type mode_ff;
  cmts_role_type auxRole_ff;
  cmts_role_type t4Role_ff;
  logic pending_ff;

  // pins pass two flops before use
  logic [2:0] pinSync;
  cmts_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din({secondFuncIn, term4EnIn, modeSelIn}),
    .dout(pinSync)
  );
  wire modeSel = pinSync[0];
  wire term4En = pinSync[1];
  wire secondSel = pinSync[2];

  // ---------------- mode selection ----------------
  wire [15:0] effMethod = secondSel ? method2_ff : method1_ff;

  cmts_mode_type reqMode;
  always_comb begin
    reqMode = CMTS_SPEED;
    case (effMethod)
      `CMTS_M_SPEED: reqMode = CMTS_SPEED;
      `CMTS_M_SL_SPEED: reqMode = CMTS_SPEED;
      `CMTS_M_TORQUE: reqMode = CMTS_TORQUE;
      `CMTS_M_SL_TORQUE: reqMode = CMTS_TORQUE;
      `CMTS_M_POS: reqMode = CMTS_POSITION;
      `CMTS_M_SPDTRQ: reqMode = modeSel ? CMTS_TORQUE : CMTS_SPEED;
      `CMTS_M_SL_SPDTRQ: reqMode = modeSel ? CMTS_TORQUE : CMTS_SPEED;
      `CMTS_M_SPDPOS: reqMode = modeSel ? CMTS_POSITION : CMTS_SPEED;
      `CMTS_M_POSTRQ: reqMode = modeSel ? CMTS_TORQUE : CMTS_POSITION;
      default: reqMode = CMTS_SPEED;
    endcase
  end

  // speed/torque swaps never wait; only position entry or exit does
  wire posInvolved = (reqMode == CMTS_POSITION) != (mode_ff == CMTS_POSITION);
  wire aboveLow = outFreq > lowSpd_ff;
  wire deferSwitch = posInvolved && motorRunning && aboveLow;
  wire cmts_mode_type nxt_mode = deferSwitch ? mode_ff : reqMode;

  // ---------------- terminal role decode ----------------
  wire [3:0] tlSrc = srcSel_ff[`CMTS_SRC_TL_LSB +: 4];
  wire [3:0] tcSrc = srcSel_ff[`CMTS_SRC_TC_LSB +: 4];
  wire [3:0] slSel = srcSel_ff[`CMTS_SRC_SL_LSB +: 4];

  cmts_dec_if auxIf ();
  cmts_dec_if t4If ();

  // decode on the next mode so roles and mode move on one edge
  assign auxIf.func = auxFunc_ff;
  assign auxIf.method = effMethod;
  assign auxIf.mode = nxt_mode;
  assign auxIf.tlSrc = tlSrc;
  assign auxIf.tcSrc = tcSrc;
  assign auxIf.slSel = slSel;
  assign auxIf.t4En = term4En;

  assign t4If.func = t4Func_ff;
  assign t4If.method = effMethod;
  assign t4If.mode = nxt_mode;
  assign t4If.tlSrc = tlSrc;
  assign t4If.tcSrc = tcSrc;
  assign t4If.slSel = slSel;
  assign t4If.t4En = term4En;

  cmts_term_decode #(.IS_AUX(1'b1)) u_aux_dec (
    .io(auxIf)
  );

  cmts_term_decode #(.IS_AUX(1'b0)) u_t4_dec (
    .io(t4If)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= CMTS_SPEED;
      auxRole_ff <= CMTS_R_NONE;
      t4Role_ff <= CMTS_R_NONE;
      pending_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      auxRole_ff <= auxIf.role;
      t4Role_ff <= t4If.role;
      pending_ff <= deferSwitch;
    end
  end

  assign activeMode = mode_ff;
  assign auxRole = auxRole_ff;
  assign term4Role = t4Role_ff;
  assign switchPending = pending_ff;

  // ---------------- AXI4-Lite write ----------------
  // address and data are taken in either order, one write at a time
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire wrHaveAddr = awHeld_ff || awTake;
  wire wrHaveData = wHeld_ff || wTake;
  wire [7:0] wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
  wire [31:0] wrData = wHeld_ff ? wData_ff : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
  wire wrFire = wrHaveAddr && wrHaveData && !bvalid_ff;

  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready = !wHeld_ff && !bvalid_ff;

  wire selM1 = wrAddr == `CMTS_OFF_METHOD1;
  wire selM2 = wrAddr == `CMTS_OFF_METHOD2;
  wire selAux = wrAddr == `CMTS_OFF_AUXFUNC;
  wire selT4 = wrAddr == `CMTS_OFF_T4FUNC;
  wire selSrc = wrAddr == `CMTS_OFF_SRCSEL;
  wire selLow = wrAddr == `CMTS_OFF_LOWSPD;
  wire selSt = wrAddr == `CMTS_OFF_STATUS;
  wire wrMapped = selM1 || selM2 || selAux || selT4 || selSrc || selLow || selSt;

  // upper lanes hold no bits, so only lanes 0 and 1 matter
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [15:0] r;
    r = cur;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  wire [15:0] nxt_method1 = (wrFire && selM1) ? merge(method1_ff, wrData, wrStrb) : method1_ff;
  wire [15:0] nxt_method2 = (wrFire && selM2) ? merge(method2_ff, wrData, wrStrb) : method2_ff;
  wire [15:0] nxt_auxFunc = (wrFire && selAux) ? merge(auxFunc_ff, wrData, wrStrb) : auxFunc_ff;
  wire [15:0] nxt_t4Func = (wrFire && selT4) ? merge(t4Func_ff, wrData, wrStrb) : t4Func_ff;
  wire [15:0] nxt_srcSel = (wrFire && selSrc) ? merge(srcSel_ff, wrData, wrStrb) : srcSel_ff;
  wire [15:0] nxt_lowSpd = (wrFire && selLow) ? merge(lowSpd_ff, wrData, wrStrb) : lowSpd_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      method1_ff <= `CMTS_RST_METHOD1;
      method2_ff <= `CMTS_RST_METHOD2;
      auxFunc_ff <= `CMTS_RST_AUXFUNC;
      t4Func_ff <= `CMTS_RST_T4FUNC;
      srcSel_ff <= `CMTS_RST_SRCSEL;
      lowSpd_ff <= `CMTS_RST_LOWSPD;
    end else begin
      method1_ff <= nxt_method1;
      method2_ff <= nxt_method2;
      auxFunc_ff <= nxt_auxFunc;
      t4Func_ff <= nxt_t4Func;
      srcSel_ff <= nxt_srcSel;
      lowSpd_ff <= nxt_lowSpd;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
    end else if (wrFire) begin
      awHeld_ff <= 1'b0;
    end else if (awTake) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else if (wrFire) begin
      wHeld_ff <= 1'b0;
    end else if (wTake) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end
  end

  // status writes are dropped silently but still answered OKAY
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ---------------- AXI4-Lite read ----------------
  wire arTake = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_ff;

  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[`CMTS_ST_MODE_LSB +: 2] = mode_ff;
    statusWord[`CMTS_ST_AUX_LSB +: 4] = auxRole_ff;
    statusWord[`CMTS_ST_T4_LSB +: 4] = t4Role_ff;
    statusWord[`CMTS_ST_PEND_BIT] = pending_ff;
    statusWord[`CMTS_ST_SECOND_BIT] = secondSel;
  end

  logic [31:0] rdMux;
  logic rdMapped;
  always_comb begin
    rdMux = 32'h00000000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      `CMTS_OFF_METHOD1: rdMux = {16'h0000, method1_ff};
      `CMTS_OFF_METHOD2: rdMux = {16'h0000, method2_ff};
      `CMTS_OFF_AUXFUNC: rdMux = {16'h0000, auxFunc_ff};
      `CMTS_OFF_T4FUNC: rdMux = {16'h0000, t4Func_ff};
      `CMTS_OFF_SRCSEL: rdMux = {16'h0000, srcSel_ff};
      `CMTS_OFF_LOWSPD: rdMux = {16'h0000, lowSpd_ff};
      `CMTS_OFF_STATUS: rdMux = statusWord;
      default: rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (arTake) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rdMux;
      rresp_ff <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule
`default_nettype wire

// >>> dv/cmts_switch_assertions.sv
// Purpose: property checks on the mode and terminal role outputs
// Assumes: role codes of cmts_pkg, pins reach the outputs three edges later
// Notes: checks only relations that hold for every method setting
`timescale 1ns/1ps
`default_nettype none
module cmts_switch_assertions import cmts_pkg::*; (
  input wire logic mclk, // clock
  input wire logic nrst, // async reset, low
  input wire logic term4EnIn, // terminal 4 enable pin
  input wire logic motorRunning, // drive running
  input wire logic [1:0] activeMode, // active mode
  input wire logic [3:0] auxRole, // aux terminal role
  input wire logic [3:0] term4Role, // terminal 4 role
  input wire logic switchPending // deferred switch
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_mode_legal;
    activeMode != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("unused mode code on output");
  property p_pend_hold;
    switchPending |-> $stable(activeMode);
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("mode moved while a switch was deferred");
  property p_pend_run;
    switchPending |-> $past(motorRunning);
  endproperty
  a_pend_run: assert property (p_pend_run)
    else $error("switch deferred with motor stopped");
  property p_spdlim_aux;
    auxRole == CMTS_R_SPDLIM_AUX |-> activeMode == CMTS_TORQUE;
  endproperty
  a_spdlim_aux: assert property (p_spdlim_aux)
    else $error("speed-limit auxiliary outside torque mode");
  property p_trq_cmd;
    auxRole == CMTS_R_TRQ_CMD |-> activeMode == CMTS_TORQUE;
  endproperty
  a_trq_cmd: assert property (p_trq_cmd)
    else $error("torque command outside torque mode");
  property p_fwdrev;
    auxRole == CMTS_R_FWDREV_LIM |-> activeMode == CMTS_TORQUE;
  endproperty
  a_fwdrev: assert property (p_fwdrev)
    else $error("direction speed limit outside torque mode");
  property p_regen;
    auxRole == CMTS_R_REGEN_TL |-> activeMode != CMTS_TORQUE;
  endproperty
  a_regen: assert property (p_regen)
    else $error("regenerative limit in torque mode");
  property p_bias;
    auxRole == CMTS_R_TRQ_BIAS |-> activeMode == CMTS_SPEED;
  endproperty
  a_bias: assert property (p_bias)
    else $error("torque bias outside speed mode");
  property p_t4_cmd;
    term4Role == CMTS_R_SPD_CMD |-> activeMode == CMTS_SPEED && $past(term4EnIn, 3);
  endproperty
  a_t4_cmd: assert property (p_t4_cmd)
    else $error("terminal 4 speed command without speed mode or enable");
  property p_t4_lim;
    term4Role == CMTS_R_SPD_LIM |-> activeMode == CMTS_TORQUE && $past(term4EnIn, 3);
  endproperty
  a_t4_lim: assert property (p_t4_lim)
    else $error("terminal 4 speed limit without torque mode or enable");
  property p_t4_tl;
    term4Role == CMTS_R_TRQ_LIM |-> activeMode != CMTS_TORQUE;
  endproperty
  a_t4_tl: assert property (p_t4_tl)
    else $error("terminal 4 torque limit in torque mode");
endmodule
bind cmts_switch cmts_switch_assertions u_chk (.mclk(mclk), .nrst(nrst),
  .term4EnIn(term4EnIn), .motorRunning(motorRunning), .activeMode(activeMode),
  .auxRole(auxRole), .term4Role(term4Role), .switchPending(switchPending));
`default_nettype wire

// >>> dv/cmts_ctrl_model.sv
// Purpose: external controller driving the digital input terminals
// Assumes: terminals already assigned to mode select, enable, second select
// Notes: levels change only just after a clock edge, never mid-cycle
`timescale 1ns/1ps
`default_nettype none
module cmts_ctrl_model (
  input wire logic mclk, // clock
  input wire logic wantMode, // requested mode select level
  input wire logic wantT4, // requested terminal 4 enable level
  input wire logic wantSecond, // requested second select level
  output logic modeSelPin, // mode select terminal
  output logic t4EnPin, // terminal 4 enable terminal
  output logic secondPin // second function terminal
);
  // roles are fixed before traffic, so no reassignment mid-run
  always_ff @(posedge mclk) begin
    modeSelPin <= wantMode;
    t4EnPin <= wantT4;
    secondPin <= wantSecond;
  end
endmodule
`default_nettype wire

// >>> dv/tb_cmts_switch.sv
// Purpose: self-checking bench for the mode and terminal role switch
// Assumes: status word layout second,pending,t4 role,aux role,mode
// Notes: every mode and role result is read back through the status register
`timescale 1ns/1ps
`default_nettype none
module tb_cmts_switch;
  logic mclk, nrst, wMode, wT4, wSec, run, modeSel, t4En, secSel, pend;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] actMode, bresp, rresp;
  logic [3:0] auxR, t4R;
  logic [7:0] awaddr, araddr;
  logic [15:0] freq, seed, thr;
  logic [31:0] wdata, rdata;
  logic [33:0] expq[$];
  int n_mismatch, n_compared, m, s, i;
  logic [15:0] fn [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h270F};
  logic [15:0] meth [4] = '{16'h000C, 16'h0002, 16'h0004, 16'h0005};
  // one nibble per function setting, setting 0 leftmost
  logic [31:0] auxTab [8] = '{32'h1040_6000, 32'h2005_5700, 32'h1340_6000, 32'h2305_5700,
    32'h1340_6080, 32'h0340_6000, 32'h0340_6000, 32'h1305_5700};
  logic [31:0] t4Tab [8] = '{32'h9000_6000, 32'hA000_0000, 32'h9300_6000, 32'hA300_0000,
    32'h9300_6000, 32'h0300_6000, 32'h0300_6000, 32'hA300_0000};
  logic [1:0] mdTab [8] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1};
  logic [31:0] rstv [7] = '{32'h14, 32'h270F, 32'h0, 32'h0, 32'h0, 32'h96, 32'h10};

  cmts_ctrl_model u_ctrl (.mclk(mclk), .wantMode(wMode), .wantT4(wT4), .wantSecond(wSec),
    .modeSelPin(modeSel), .t4EnPin(t4En), .secondPin(secSel));
  cmts_switch dut (.mclk(mclk), .nrst(nrst), .modeSelIn(modeSel), .term4EnIn(t4En),
    .secondFuncIn(secSel), .motorRunning(run), .outFreq(freq), .activeMode(actMode),
    .auxRole(auxR), .term4Role(t4R), .switchPending(pend), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] st(input logic sc, pd, input logic [3:0] t4, ax,
      input logic [1:0] md);
    return {18'h0, sc, pd, t4, ax, 2'h0, md};
  endfunction
  function automatic logic [33:0] nextExp();
    if (expq.size() == 0) return 34'h3_FFFF_FFFF;
    return expq.pop_front();
  endfunction
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    expq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    if (k == 50) begin
      n_mismatch++;
      close_out();
    end
    @(posedge mclk);
  endtask
  task automatic axRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    expq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    if (k == 50) begin
      n_mismatch++;
      close_out();
    end
    @(posedge mclk);
  endtask
  task automatic pins(input logic md, t4, sc, rn, input logic [15:0] f);
    wMode <= md;
    wT4 <= t4;
    wSec <= sc;
    run <= rn;
    freq <= f;
  endtask
  // model edge, two sync edges, output edge, one spare
  task automatic stat(input logic [31:0] e);
    repeat (5) @(posedge mclk);
    axRead(8'h18, e, 2'h0);
  endtask

  // status reads also hold the mode and role pins against the same note
  always @(posedge mclk) begin : mon
    logic [33:0] e;
    if (bvalid === 1'h1 && bready) check({bresp, 32'h0}, nextExp());
    if (rvalid === 1'h1 && rready) begin
      e = nextExp();
      check({rresp, rdata}, e);
      if (araddr == 8'h18)
        check({21'h0, pend, t4R, auxR, 2'h0, actMode}, {21'h0, e[12:4], 2'h0, e[1:0]});
    end
  end

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    {nrst, wMode, wT4, wSec, run, awvalid, wvalid, bready, arvalid, rready} = 10'h0;
    {awaddr, araddr, freq, wdata} = 64'h0;
    seed = 16'h0056;
    repeat (10) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    for (i = 0; i < 7; i++) axRead(8'(i * 4), rstv[i], 2'h0);
    axRead(8'h1C, 32'h0, 2'h2);
    axWrite(8'h18, 32'hFFFF, 2'h0);
    stat(32'h10);
    seed = lfsr(seed);
    thr = {1'h0, seed[14:0]};
    axWrite(8'h14, {16'h0, thr}, 2'h0);
    axRead(8'h14, {16'h0, thr}, 2'h0);
    axWrite(8'h10, 32'h0201, 2'h0);
    // motor stopped so no switch is deferred in the table sweep
    for (m = 0; m < 4; m++) begin
      axWrite(8'h00, {16'h0, meth[m]}, 2'h0);
      for (s = 0; s < 2; s++) begin
        pins(s[0], 1'h1, 1'h0, 1'h0, 16'h0);
        for (i = 0; i < 8; i++) begin
          axWrite(8'h08, {16'h0, fn[i]}, 2'h0);
          axWrite(8'h0C, {16'h0, (i == 2 || i == 3 || i == 5 || i == 6) ? 16'h270F : fn[i]},
            2'h0);
          stat(st(1'h0, 1'h0, t4Tab[2*m+s][(7-i)*4 +: 4], auxTab[2*m+s][(7-i)*4 +: 4],
            mdTab[2*m+s]));
        end
      end
    end
    seed = lfsr(seed);
    axWrite(8'h00, 32'h2, 2'h0);
    axWrite(8'h08, 32'h0, 2'h0);
    axWrite(8'h0C, 32'h0, 2'h0);
    pins(1'h0, 1'h1, 1'h0, 1'h1, thr + 16'h1 + {8'h0, seed[7:0]});
    stat(st(1'h0, 1'h0, 4'h9, 4'h1, 2'h0));
    pins(1'h1, 1'h1, 1'h0, 1'h1, thr + 16'h1);
    stat(st(1'h0, 1'h0, 4'hA, 4'h2, 2'h1));
    pins(1'h0, 1'h1, 1'h0, 1'h1, thr + 16'h1);
    stat(st(1'h0, 1'h0, 4'h9, 4'h1, 2'h0));
    axWrite(8'h00, 32'h4, 2'h0);
    pins(1'h1, 1'h1, 1'h0, 1'h1, thr + 16'h1);
    stat(st(1'h0, 1'h1, 4'h9, 4'h1, 2'h0));
    pins(1'h1, 1'h1, 1'h0, 1'h1, thr);
    stat(st(1'h0, 1'h0, 4'h0, 4'h0, 2'h2));
    axWrite(8'h04, 32'hC, 2'h0);
    axWrite(8'h00, 32'h14, 2'h0);
    pins(1'h1, 1'h1, 1'h1, 1'h0, 16'h0);
    stat(st(1'h1, 1'h0, 4'hA, 4'h2, 2'h1));
    pins(1'h1, 1'h0, 1'h1, 1'h0, 16'h0);
    stat(st(1'h1, 1'h0, 4'h0, 4'h2, 2'h1));
    pins(1'h1, 1'h1, 1'h0, 1'h0, 16'h0);
    stat(st(1'h0, 1'h0, 4'h9, 4'h1, 2'h0));
    close_out();
  end
endmodule
`default_nettype wire
